// *** logic/bmbs_map.vh ***
/*
  Constants for the block-move bus sequencer: cycle counts, program counter
  steps and the levels that the bus-status outputs take.
  Assumes it is included by bare name from the design files under logic/.
*/
`ifndef BMBS_MAP_VH
`define BMBS_MAP_VH

// Clock period in ns (125 MHz).
`define BMBS_CLK_PERIOD_NS 8

// Bus cycles per byte moved in emulation mode and in native mode.
`define BMBS_CYC_PER_BYTE_EMU 8'h07
`define BMBS_CYC_PER_BYTE_NAT 8'h05

// Distance from the block-move opcode to the next opcode.
`define BMBS_PC_STEP_EMU 16'h0003
`define BMBS_PC_STEP_NAT 16'h0001

// Operand offsets of the destination and source bank bytes.
`define BMBS_DST_BANK_OFFSET 16'h0001
`define BMBS_SRC_BANK_OFFSET 16'h0002

// Read level of the read/write line and idle level of the low-true outputs.
`define BMBS_RW_READ 1'b1
`define BMBS_RW_WRITE 1'b0
`define BMBS_INACTIVE_N 1'b1

// Reset values.
`define BMBS_RST_ADDR 24'h000000
`define BMBS_RST_BYTE 8'h00

`endif

// *** logic/bmbs_index_step.v ***
/*
  Index stepper: adds or subtracts one from an index register value.
  Assumes a purely combinational use by the sequencer on the same clock.
*/
`timescale 1ns/100ps

module bmbs_index_step #(
  parameter W = 16
) (
  input wire [W-1:0] value_in,
  input wire descend_in,
  output wire [W-1:0] value_out
);

  // Ascending moves count up, descending moves count down; both wrap.
  assign value_out = descend_in ? (value_in - {{(W-1){1'b0}}, 1'b1}) :
                                  (value_in + {{(W-1){1'b0}}, 1'b1});

endmodule

// *** logic/bmbs_sequencer.v ***
/*
  Bus-cycle sequencer for the block-move instructions of the processor.
  It runs the opcode and operand fetches, one read and one write per byte,
  two internal cycles per byte, steps the index registers and the byte count,
  and then fetches the next opcode.
  Assumes memory answers read data on data_in within the read cycle on the
  same clock; the abort pin is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps
`include "bmbs_map.vh"

// How it works
// (RQ1) Fetch opcode at program bank and PC, then destination and source bank bytes.
// (RQ2) Per byte: read source, write destination, two idle cycles; seven cycles.
// (RQ3) X gives the source index, Y the destination, accumulator holds count minus one.
// (RQ4) Ascending move adds one to X and Y after every byte.
// (RQ5) Software picks the ascending move when destination starts below source.
// (RQ6) After the last byte fetch the next opcode at PC plus three.
// (RQ7) Native mode drops the two operand fetches: two bytes, two cycles fewer.
// (RQ8) Both address-valid outputs high only during opcode fetches.
// (RQ9) Read/write line stays at read while reset is applied.
// (RQ10) Abort is honoured only up to the read cycle; later it changes nothing.
// (RQ11) Descending move subtracts one from X and Y after every byte.
// (RQ12) Vector-pull and memory-lock stay high through every block-move cycle.
module bmbs_sequencer #(
  parameter IDX_W = 16
) (
  input wire clk_in,
  input wire reset_in,
  input wire start_in,
  input wire descend_in,
  input wire native_mode_in,
  input wire [7:0] program_bank_reg_in,
  input wire [15:0] pc_in,
  input wire [IDX_W-1:0] x_in,
  input wire [IDX_W-1:0] y_in,
  input wire [IDX_W-1:0] count_in,
  input wire [7:0] dest_bank_value_in,
  input wire [7:0] source_bank_value_in,
  input wire [7:0] data_in,
  input wire abort_n_in,
  output reg [23:0] addr_out,
  output reg [7:0] data_out,
  output reg data_oe_out,
  output reg read_write_out,
  output reg data_addr_valid_out,
  output reg program_addr_valid_out,
  output reg vector_pull_n_out,
  output reg memory_lock_n_out,
  output reg [IDX_W-1:0] x_out,
  output reg [IDX_W-1:0] y_out,
  output reg [IDX_W-1:0] count_out,
  output reg [7:0] data_bank_reg_out,
  output reg [15:0] pc_out,
  output reg busy_out,
  output reg done_out,
  output reg aborted_out
);

  // **********************************************************************
  // States
  // **********************************************************************
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_OPC = 4'h1;
  localparam [3:0] S_DST_BANK = 4'h2;
  localparam [3:0] S_SRC_BANK = 4'h3;
  localparam [3:0] S_READ = 4'h4;
  localparam [3:0] S_WRITE = 4'h5;
  localparam [3:0] S_IO1 = 4'h6;
  localparam [3:0] S_IO2 = 4'h7;
  localparam [3:0] S_NEXT = 4'h8;

  function [23:0] bank_addr;
    input [7:0] bank;
    input [15:0] offset;
    begin
      bank_addr = {bank, offset};
    end
  endfunction

  reg [3:0] state;
  reg [3:0] next_state;
  reg abort_meta;
  reg abort_sync_n;
  reg descend;
  reg native;
  reg [7:0] prog_bank;
  reg [15:0] pc;
  reg [7:0] src_bank;
  reg [7:0] dst_bank;
  reg [7:0] held_byte;
  reg [IDX_W-1:0] x_idx;
  reg [IDX_W-1:0] y_idx;
  reg [IDX_W-1:0] count;
  wire [7:0] src_bank_now;
  wire [IDX_W-1:0] x_stepped;
  wire [IDX_W-1:0] y_stepped;
  wire abort_req;
  wire last_byte;

  // **********************************************************************
  // Index stepping
  // **********************************************************************
  bmbs_index_step #(.W(IDX_W)) x_step (
    .value_in(x_idx),
    .descend_in(descend),
    .value_out(x_stepped)
  );

  bmbs_index_step #(.W(IDX_W)) y_step (
    .value_in(y_idx),
    .descend_in(descend),
    .value_out(y_stepped)
  );

  assign abort_req = ~abort_sync_n;
  assign last_byte = (count == {IDX_W{1'b0}});

  // **********************************************************************
  // Abort synchroniser
  // **********************************************************************
  always @(posedge clk_in) begin
    if (reset_in) begin
      abort_meta <= `BMBS_INACTIVE_N;
      abort_sync_n <= `BMBS_INACTIVE_N;
    end else begin
      abort_meta <= abort_n_in;
      abort_sync_n <= abort_meta;
    end
  end

  // **********************************************************************
  // Next state
  // **********************************************************************
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: next_state = start_in ? S_OPC : S_IDLE;
      S_OPC: begin
        if (abort_req) begin
          next_state = S_IDLE; // [RQ10]
        end else if (native) begin
          next_state = S_READ; // [RQ7]
        end else begin
          next_state = S_DST_BANK; // [RQ1]
        end
      end
      S_DST_BANK: next_state = abort_req ? S_IDLE : S_SRC_BANK; // [RQ1] [RQ10]
      S_SRC_BANK: next_state = abort_req ? S_IDLE : S_READ; // [RQ10]
      // The read cycle is the last one that an abort may cancel.
      S_READ: next_state = abort_req ? S_IDLE : S_WRITE; // [RQ10]
      S_WRITE: next_state = S_IO1; // [RQ2]
      S_IO1: next_state = S_IO2; // [RQ2]
      S_IO2: next_state = last_byte ? S_NEXT : S_OPC; // [RQ6]
      S_NEXT: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  assign src_bank_now = (state == S_SRC_BANK) ? data_in : src_bank;

  // **********************************************************************
  // Working registers
  // **********************************************************************
  always @(posedge clk_in) begin
    if (reset_in) begin
      state <= S_IDLE;
      descend <= 1'b0;
      native <= 1'b0;
      prog_bank <= 8'h00;
      pc <= 16'h0000;
      src_bank <= `BMBS_RST_BYTE;
      dst_bank <= `BMBS_RST_BYTE;
      held_byte <= `BMBS_RST_BYTE;
      x_idx <= {IDX_W{1'b0}};
      y_idx <= {IDX_W{1'b0}};
      count <= {IDX_W{1'b0}};
    end else begin
      state <= next_state;
      if (state == S_IDLE && start_in) begin
        descend <= descend_in;
        native <= native_mode_in;
        prog_bank <= program_bank_reg_in;
        pc <= pc_in;
        x_idx <= x_in; // [RQ3]
        y_idx <= y_in; // [RQ3]
        count <= count_in; // [RQ3]
        src_bank <= source_bank_value_in;
        dst_bank <= dest_bank_value_in;
      end
      if (state == S_DST_BANK)
        dst_bank <= data_in; // [RQ1]
      if (state == S_SRC_BANK)
        src_bank <= data_in; // [RQ1]
      if (state == S_READ)
        held_byte <= data_in; // [RQ2]
      if (state == S_IO2) begin
        x_idx <= x_stepped; // [RQ4] [RQ11]
        y_idx <= y_stepped; // [RQ4] [RQ11]
        count <= count - {{(IDX_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // **********************************************************************
  // Bus outputs, registered from the state being entered
  // **********************************************************************
  always @(posedge clk_in) begin
    if (reset_in) begin
      addr_out <= `BMBS_RST_ADDR;
      data_out <= `BMBS_RST_BYTE;
      data_oe_out <= 1'b0;
      read_write_out <= `BMBS_RW_READ; // [RQ9]
      data_addr_valid_out <= 1'b0;
      program_addr_valid_out <= 1'b0;
      vector_pull_n_out <= `BMBS_INACTIVE_N;
      memory_lock_n_out <= `BMBS_INACTIVE_N;
      busy_out <= 1'b0;
    end else begin
      vector_pull_n_out <= `BMBS_INACTIVE_N; // [RQ12]
      memory_lock_n_out <= `BMBS_INACTIVE_N; // [RQ12]
      data_out <= held_byte;
      data_oe_out <= 1'b0;
      read_write_out <= `BMBS_RW_READ;
      data_addr_valid_out <= 1'b0;
      program_addr_valid_out <= 1'b0;
      busy_out <= (next_state != S_IDLE);
      case (next_state)
        S_OPC: begin
          // On a fresh start the bank and counter registers load at this same edge.
          addr_out <= (state == S_IDLE) ? bank_addr(program_bank_reg_in, pc_in) :
                                          bank_addr(prog_bank, pc); // [RQ1]
          data_addr_valid_out <= 1'b1; // [RQ8]
          program_addr_valid_out <= 1'b1; // [RQ8]
        end
        S_DST_BANK: begin
          addr_out <= bank_addr(prog_bank, pc + `BMBS_DST_BANK_OFFSET); // [RQ1]
          program_addr_valid_out <= 1'b1; // [RQ1]
        end
        S_SRC_BANK: begin
          addr_out <= bank_addr(prog_bank, pc + `BMBS_SRC_BANK_OFFSET); // [RQ1]
          program_addr_valid_out <= 1'b1; // [RQ1]
        end
        S_READ: begin
          addr_out <= bank_addr(src_bank_now, x_idx[15:0]); // [RQ2] [RQ3]
          data_addr_valid_out <= 1'b1;
        end
        S_WRITE: begin
          addr_out <= bank_addr(dst_bank, y_idx[15:0]); // [RQ2] [RQ3]
          data_addr_valid_out <= 1'b1;
          read_write_out <= `BMBS_RW_WRITE;
          data_oe_out <= 1'b1;
          data_out <= data_in;
        end
        S_IO1, S_IO2: addr_out <= bank_addr(dst_bank, y_idx[15:0]); // [RQ2]
        S_NEXT: begin
          addr_out <= bank_addr(prog_bank, pc + (native ? `BMBS_PC_STEP_NAT :
                                                 `BMBS_PC_STEP_EMU)); // [RQ6] [RQ7]
          data_addr_valid_out <= 1'b1; // [RQ8]
          program_addr_valid_out <= 1'b1; // [RQ8]
        end
        default: addr_out <= addr_out;
      endcase
    end
  end

  // **********************************************************************
  // Architectural results and completion
  // **********************************************************************
  always @(posedge clk_in) begin
    if (reset_in) begin
      x_out <= {IDX_W{1'b0}};
      y_out <= {IDX_W{1'b0}};
      count_out <= {IDX_W{1'b0}};
      data_bank_reg_out <= 8'h00;
      pc_out <= 16'h0000;
      done_out <= 1'b0;
      aborted_out <= 1'b0;
    end else begin
      done_out <= (state == S_NEXT);
      aborted_out <= (next_state == S_IDLE) && abort_req &&
                     (state == S_OPC || state == S_DST_BANK || state == S_SRC_BANK ||
                      state == S_READ); // [RQ10]
      if (state == S_IO2) begin
        // Past the read cycle an abort no longer holds these back.
        x_out <= x_stepped; // [RQ4] [RQ11]
        y_out <= y_stepped; // [RQ4] [RQ11]
        count_out <= count - {{(IDX_W-1){1'b0}}, 1'b1};
        data_bank_reg_out <= dst_bank; // [RQ10]
        pc_out <= last_byte ? pc + (native ? `BMBS_PC_STEP_NAT : `BMBS_PC_STEP_EMU) : pc; // [RQ6]
      end
    end
  end

endmodule

// *** test/bmbs_sequencer_sva.sv ***
/*
  Concurrent checks on the ports of the block-move bus sequencer.
  Assumes one clock and the synchronous active-high reset of the design.
*/
`timescale 1ns/100ps
module bmbs_sequencer_sva #(
  parameter IDX_W = 16
) (
  input wire clk_in,
  input wire reset_in,
  input wire start_in,
  input wire native_mode_in,
  input wire abort_n_in,
  input wire busy_out,
  input wire done_out,
  input wire [7:0] program_bank_reg_in,
  input wire [15:0] pc_in,
  input wire [15:0] pc_out,
  input wire [IDX_W-1:0] y_out,
  input wire [23:0] addr_out,
  input wire data_oe_out,
  input wire read_write_out,
  input wire data_addr_valid_out,
  input wire program_addr_valid_out,
  input wire vector_pull_n_out,
  input wire memory_lock_n_out
);
  // ****************************************
  // Bus-cycle checks
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_rw_reset: assert property (disable iff (1'b0) $past(reset_in) |-> read_write_out)
    else $error("read/write line not at read level in reset");
  a_pull_lock_idle: assert property (vector_pull_n_out && memory_lock_n_out)
    else $error("vector pull or memory lock asserted");
  a_start_fetch: assert property (start_in && !busy_out |=> data_addr_valid_out &&
    program_addr_valid_out && addr_out == {$past(program_bank_reg_in), $past(pc_in)})
    else $error("opcode fetch missing after start");
  a_operand_fetch: assert property (start_in && !busy_out && !native_mode_in && abort_n_in
    |=> ##1 (!data_addr_valid_out && program_addr_valid_out &&
    addr_out == {$past(program_bank_reg_in, 2), $past(pc_in, 2) + 16'h0001}))
    else $error("operand fetch wrong");
  a_write_after_read: assert property (!read_write_out |-> data_oe_out &&
    $past(data_addr_valid_out && !program_addr_valid_out && read_write_out))
    else $error("write not preceded by read");
  a_internal_pair: assert property (!read_write_out |=>
    (!data_addr_valid_out && !program_addr_valid_out && read_write_out) [*2])
    else $error("internal cycles wrong after write");
  a_index_step: assert property (!read_write_out |-> ##3
    (y_out == $past(addr_out[15:0], 3) + 16'h0001 || y_out == $past(addr_out[15:0], 3) - 16'h0001))
    else $error("destination index not stepped by one");
  a_done_next_pc: assert property (done_out |-> !busy_out &&
    $past(data_addr_valid_out && program_addr_valid_out) && $past(addr_out[15:0]) == pc_out)
    else $error("done without next opcode fetch");
endmodule

bind bmbs_sequencer bmbs_sequencer_sva #(.IDX_W(IDX_W)) bmbs_sequencer_sva_inst (.clk_in,
  .reset_in, .start_in, .native_mode_in, .abort_n_in, .busy_out, .done_out,
  .program_bank_reg_in, .pc_in, .pc_out, .y_out, .addr_out, .data_oe_out, .read_write_out,
  .data_addr_valid_out, .program_addr_valid_out, .vector_pull_n_out, .memory_lock_n_out);

// *** test/bmbs_memory_model.sv ***
/*
  Behavioural memory on the far side of the sequencer's bus.
  Assumes read data is sampled at the edge that ends each valid read cycle.
*/
`timescale 1ns/100ps
module bmbs_memory_model (
  input wire logic clk_in,
  input wire logic [23:0] addr_in,
  input wire logic rd_wr_in,
  input wire logic dav_in,
  input wire logic pav_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out
);
  // ****************************************
  // Storage and read path
  // ****************************************
  logic [7:0] mem [logic [23:0]];
  initial rd_data_out = 8'h00;
  // Outside valid reads the bus shows the inverse of the last value, never a held byte.
  always @(posedge clk_in) begin
    if (!rd_wr_in && wr_en_in)
      mem[addr_in] = wr_data_in;
    #1;
    if (rd_wr_in && (dav_in || pav_in))
      rd_data_out = mem.exists(addr_in) ? mem[addr_in] :
        (addr_in[7:0] ^ addr_in[15:8] ^ addr_in[23:16] ^ 8'h3c);
    else
      rd_data_out = ~rd_data_out;
  end
endmodule

// *** test/test_bmbs_sequencer.sv ***
/*
  Self-checking testbench for the block-move bus sequencer.
  Assumes the memory model answers reads and records writes.
*/
`timescale 1ns/100ps
module test_bmbs_sequencer;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0, descend_in = 1'b0, native_mode_in = 1'b0, abort_n_in = 1'b1;
  logic [7:0] program_bank_reg_in = 8'h01, dest_bank_value_in = 8'h00;
  logic [7:0] source_bank_value_in = 8'h00;
  logic [15:0] pc_in = 16'h0000, x_in = 16'h0000, y_in = 16'h0000, count_in = 16'h0000;
  wire [7:0] data_in, data_out, data_bank_reg_out;
  wire [23:0] addr_out;
  wire [15:0] x_out, y_out, count_out, pc_out;
  wire data_oe_out, read_write_out, data_addr_valid_out, program_addr_valid_out;
  wire vector_pull_n_out, memory_lock_n_out, busy_out, done_out, aborted_out;
  integer fail_count = 0, n_checks = 0, n;
  integer n_aborts = 0;

  bmbs_sequencer #(.IDX_W(16)) bmbs_sequencer_inst (.clk_in, .reset_in, .start_in,
    .descend_in, .native_mode_in, .program_bank_reg_in, .pc_in, .x_in, .y_in, .count_in,
    .dest_bank_value_in, .source_bank_value_in, .data_in, .abort_n_in, .addr_out, .data_out,
    .data_oe_out, .read_write_out, .data_addr_valid_out, .program_addr_valid_out,
    .vector_pull_n_out, .memory_lock_n_out, .x_out, .y_out, .count_out, .data_bank_reg_out,
    .pc_out, .busy_out, .done_out, .aborted_out);
  bmbs_memory_model bmbs_memory_model_inst (.clk_in, .addr_in(addr_out),
    .rd_wr_in(read_write_out), .dav_in(data_addr_valid_out), .pav_in(program_addr_valid_out),
    .wr_en_in(data_oe_out), .wr_data_in(data_out), .rd_data_out(data_in));

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (aborted_out === 1'b1) n_aborts <= n_aborts + 1;

  // ****************************************
  // Checking tasks
  // ****************************************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One move; late is the cycle index at which a one-cycle abort pulse is driven.
  task automatic move(input logic desc, nat, input logic [15:0] cnt, xs, yd, pc,
                      input logic [7:0] sb, db, input integer late);
    logic [15:0] st;
    integer i;
    integer a0;
    st = desc ? 16'hffff : 16'h0001;
    bmbs_memory_model_inst.mem[{8'h01, pc + 16'h0001}] = db;
    bmbs_memory_model_inst.mem[{8'h01, pc + 16'h0002}] = sb;
    @(posedge clk_in);
    {descend_in, native_mode_in, count_in, x_in, y_in, pc_in} <= {desc, nat, cnt, xs, yd, pc};
    source_bank_value_in <= sb;
    dest_bank_value_in <= db;
    start_in <= 1'b1;
    a0 = n_aborts;
    @(posedge clk_in);
    start_in <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      abort_n_in <= (n == late) ? 1'b0 : 1'b1;
      #1;
      n++;
    end
    chk("cycles", (nat ? 5 : 7) * (cnt + 1) + 1, 24'(n));
    chk("late abort", 24'h0, 24'(n_aborts - a0));
    for (i = 0; i <= cnt; i++) begin
      chk("dest byte", {16'h0, sb ^ xs[15:8] ^ xs[7:0] ^ 8'h3c},
          {16'h0, bmbs_memory_model_inst.mem[{db, yd}]});
      xs = xs + st;
      yd = yd + st;
    end
    chk("x", {8'h0, xs}, {8'h0, x_out});
    chk("y", {8'h0, yd}, {8'h0, y_out});
    chk("count", 24'h00ffff, {8'h0, count_out});
    chk("pc", {8'h0, pc + (nat ? 16'h0001 : 16'h0003)}, {8'h0, pc_out});
    chk("data bank", {16'h0, db}, {16'h0, data_bank_reg_out});
  endtask

  task automatic early_abort();
    logic [15:0] x0;
    integer a0;
    x0 = x_out;
    a0 = n_aborts;
    @(posedge clk_in);
    {native_mode_in, start_in, abort_n_in} <= 3'b010;
    @(posedge clk_in);
    {start_in, abort_n_in} <= 2'b01;
    repeat (12) @(posedge clk_in);
    #1;
    chk("aborted", 24'h1, 24'(n_aborts - a0));
    chk("x kept", {8'h0, x0}, {8'h0, x_out});
    chk("busy", 24'h0, {23'h0, busy_out});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    #1;
    chk("rw in reset", 24'h1, {23'h0, read_write_out});
    chk("pull and lock", 24'h3, {22'h0, vector_pull_n_out, memory_lock_n_out});
    // Destination below source, so the ascending move is the one software picks.
    move(0, 0, 16'h0002, 16'h1000, 16'h0800, 16'h0200, 8'h02, 8'h03, -1);
    move(1, 0, 16'h0001, 16'h1005, 16'h2005, 16'h0300, 8'h04, 8'h04, -1);
    move(0, 1, 16'h0000, 16'hffff, 16'h0010, 16'h0500, 8'h05, 8'h06, -1);
    // This abort pulse reaches the sequencer in the write cycle, so it must change nothing.
    move(0, 0, 16'h0000, 16'h0040, 16'h0050, 16'h0600, 8'h07, 8'h08, 1);
    early_abort();
    finish_test();
  end

  initial begin
    #(8 * 2000);
    fail_count++;
    finish_test();
  end
endmodule
